/* wwdt_cfg.svh */
`ifndef WWDT_CFG_SVH
`define WWDT_CFG_SVH

// Register byte addresses
`define WWDT_ADDR_RCTL 8'h00
`define WWDT_ADDR_STAT 8'h04
`define WWDT_ADDR_CLR 8'h08
`define WWDT_ADDR_IEN 8'h0C
`define WWDT_ADDR_CNT 8'h10

// Reset control register bit positions
`define WWDT_BIT_SOFTEN 5
`define WWDT_BIT_TMO 4
`define WWDT_BIT_SLEEP 3
`define WWDT_BIT_IDLE 2

// Config word fields
`define WWDT_CFG_PS_MSB 3
`define WWDT_CFG_PS_LSB 0
`define WWDT_CFG_EN_MSB 6
`define WWDT_CFG_EN_LSB 5
`define WWDT_CFG_WINDOW_DIS 7
`define WWDT_EN_ALWAYS 2'h3
`define WWDT_EN_SOFT 2'h2

// Prescaler divide ratios
`define WWDT_PRE_SHORT 23'h000020
`define WWDT_PRE_LONG 23'h000080

// Event bit positions
`define WWDT_EV_TMO 0
`define WWDT_EV_EARLY 1
`define WWDT_EV_WAKE 2

// Reset values
`define WWDT_STAT_RST 3'h0
`define WWDT_IEN_RST 3'h0
`define WWDT_CNT_RST 23'h000000

// Bus responses
`define WWDT_RESP_OKAY 2'h0
`define WWDT_RESP_SLVERR 2'h2

`endif

/* wwdt_pkg.sv */
package wwdt_pkg;

  typedef enum logic [2:0] {
    WWDT_RUN = 3'b001,
    WWDT_IDLE = 3'b010,
    WWDT_SLEEP = 3'b100
  } wwdt_mode_t;

  typedef enum logic [1:0] {
    WWDT_SRC_LOWRC = 2'h0,
    WWDT_SRC_SECOSC = 2'h1,
    WWDT_SRC_SYSTMR = 2'h2
  } wwdt_src_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
  } wwdt_sync_t;

  typedef struct packed {
    wwdt_mode_t mode;
    logic [22:0] cnt;
    logic softEn;
    logic tmoFlag;
    logic sleepFlag;
    logic idleFlag;
    logic [2:0] stat;
    logic [2:0] ien;
    logic irq;
    logic rstReq;
    logic wake;
    logic srcEn;
    wwdt_src_t srcSel;
    logic awready;
    logic wready;
    logic arready;
    logic awHave;
    logic wHave;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wwdt_state_t;

endpackage

/* wwdt_tick_sync.sv */
`timescale 1ns/1ns
module wwdt_tick_sync (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [2:0] srcPins,
  input wire logic [1:0] srcSel,
  output logic tick
);

  wwdt_pkg::wwdt_sync_t r;
  wwdt_pkg::wwdt_sync_t n;

  always_comb begin
    n = r;
    n.s1 = srcPins;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Rising edge of the selected source
  assign tick = (srcSel < 2'h3) && r.s2[srcSel] && !r.s3[srcSel];

endmodule // wwdt_tick_sync

/* wwdt_top.sv */
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "wwdt_cfg.svh"
module wwdt_top (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic lowPowerRcOsc,
  input wire logic secondaryOsc,
  input wire logic systemTimerClk,
  input wire logic [1:0] clkSrcSelect,
  input wire logic [7:0] watchdogConfigWord,
  input wire logic prescaleWidthSelect,
  input wire logic watchdogClearCmd,
  input wire logic powerSaveCmd,
  input wire logic powerSaveIsSleep,
  input wire logic powerSaveExit,
  input wire logic clkSwitchDone,
  output logic resetReq,
  output logic wakeReq,
  output logic clkSrcEnable,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  wwdt_pkg::wwdt_state_t r;
  wwdt_pkg::wwdt_state_t n;
  logic tick;
  logic enabled;
  logic inRun;
  logic timeout;
  logic early;
  logic cntClr;
  logic windowDisable;
  logic [1:0] configEnableField;
  logic [3:0] postscaleRatioSelect;
  logic [22:0] period;
  logic [22:0] lastCnt;
  logic [22:0] winStart;
  logic [4:0] wrSel;
  logic [4:0] rdSel;
  logic doWr;
  logic rctlWr;

  function automatic logic [4:0] regSel(input logic [7:0] a);
    case (a)
      `WWDT_ADDR_RCTL: regSel = 5'h01;
      `WWDT_ADDR_STAT: regSel = 5'h02;
      `WWDT_ADDR_CLR: regSel = 5'h04;
      `WWDT_ADDR_IEN: regSel = 5'h08;
      `WWDT_ADDR_CNT: regSel = 5'h10;
      default: regSel = 5'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Clock source pins

  wwdt_tick_sync uSync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .srcPins({systemTimerClk, secondaryOsc, lowPowerRcOsc}),
    .srcSel(r.srcSel),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Period and window

  assign windowDisable = watchdogConfigWord[`WWDT_CFG_WINDOW_DIS];
  assign configEnableField =
    watchdogConfigWord[`WWDT_CFG_EN_MSB:`WWDT_CFG_EN_LSB];
  assign postscaleRatioSelect =
    watchdogConfigWord[`WWDT_CFG_PS_MSB:`WWDT_CFG_PS_LSB];

  // Prescale then postscale by two to the code
  assign period = (prescaleWidthSelect ? `WWDT_PRE_LONG : `WWDT_PRE_SHORT)
    << postscaleRatioSelect;
  assign lastCnt = period - 23'h000001;
  assign winStart = period - (period >> 2);

  assign enabled = (configEnableField == `WWDT_EN_ALWAYS) ||
    ((configEnableField == `WWDT_EN_SOFT) && r.softEn);
  assign inRun = (r.mode == wwdt_pkg::WWDT_RUN);
  assign timeout = enabled && tick && (r.cnt == lastCnt);
  assign early = enabled && inRun && watchdogClearCmd && !windowDisable &&
    (r.cnt < winStart);
  assign cntClr = clkSwitchDone || (inRun && powerSaveCmd) ||
    (!inRun && powerSaveExit) ||
    (inRun && watchdogClearCmd);

  assign doWr = r.awHave && r.wHave && !r.bvalid;
  assign wrSel = regSel(r.awAddr);
  assign rdSel = regSel(s_axi_araddr);
  assign rctlWr = doWr && r.wStrb[0] && wrSel[0];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = r;
    n.rstReq = 1'b0;
    n.wake = 1'b0;
    // Write channels
    if (s_axi_awvalid && r.awready) begin
      n.awAddr = s_axi_awaddr;
      n.awHave = 1'b1;
      n.awready = 1'b0;
    end
    if (s_axi_wvalid && r.wready) begin
      n.wData = s_axi_wdata;
      n.wStrb = s_axi_wstrb;
      n.wHave = 1'b1;
      n.wready = 1'b0;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    if (doWr) begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = (|wrSel) ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;
      if (r.wStrb[0]) begin
        if (wrSel[0]) begin
          n.softEn = r.wData[`WWDT_BIT_SOFTEN];
          n.tmoFlag = r.wData[`WWDT_BIT_TMO];
          n.sleepFlag = r.wData[`WWDT_BIT_SLEEP];
          n.idleFlag = r.wData[`WWDT_BIT_IDLE];
        end
        if (wrSel[2]) begin
          n.stat = r.stat & ~r.wData[2:0];
        end
        if (wrSel[3]) begin
          n.ien = r.wData[2:0];
        end
      end
    end
    // Read channels
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    if (s_axi_arvalid && r.arready) begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = (|rdSel) ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;
      n.rdata = 32'h00000000;
      if (rdSel[0]) begin
        n.rdata[`WWDT_BIT_SOFTEN] = r.softEn;
        n.rdata[`WWDT_BIT_TMO] = r.tmoFlag;
        n.rdata[`WWDT_BIT_SLEEP] = r.sleepFlag;
        n.rdata[`WWDT_BIT_IDLE] = r.idleFlag;
      end
      if (rdSel[1]) begin
        n.rdata[2:0] = r.stat;
      end
      if (rdSel[3]) begin
        n.rdata[2:0] = r.ien;
      end
      if (rdSel[4]) begin
        n.rdata[22:0] = r.cnt;
      end
    end
    // Clock source
    n.srcEn = enabled;
    n.srcSel = (r.mode == wwdt_pkg::WWDT_SLEEP) ?
      wwdt_pkg::WWDT_SRC_LOWRC :
      wwdt_pkg::wwdt_src_t'(clkSrcSelect);
    // Power-save modes
    case (r.mode)
      wwdt_pkg::WWDT_RUN: begin
        if (powerSaveCmd) begin
          if (powerSaveIsSleep) begin
            n.mode = wwdt_pkg::WWDT_SLEEP;
            n.sleepFlag = 1'b1;
          end else begin
            n.mode = wwdt_pkg::WWDT_IDLE;
            n.idleFlag = 1'b1;
          end
        end
      end
      wwdt_pkg::WWDT_IDLE, wwdt_pkg::WWDT_SLEEP: begin
        if (timeout) begin
          n.mode = wwdt_pkg::WWDT_RUN;
          n.wake = 1'b1;
          n.stat[`WWDT_EV_WAKE] = 1'b1;
        end else if (powerSaveExit) begin
          n.mode = wwdt_pkg::WWDT_RUN;
        end
      end
      default: begin
        n.mode = wwdt_pkg::WWDT_RUN;
      end
    endcase
    // Time-out and early clear; hardware set wins
    if (timeout || early) begin
      n.tmoFlag = 1'b1;
    end
    if ((timeout && inRun) || early) begin
      n.rstReq = 1'b1;
    end
    if (timeout && inRun) begin
      n.stat[`WWDT_EV_TMO] = 1'b1;
    end
    if (early) begin
      n.stat[`WWDT_EV_EARLY] = 1'b1;
    end
    // Counter
    if (!enabled || cntClr || timeout) begin
      n.cnt = `WWDT_CNT_RST;
    end else if (tick) begin
      n.cnt = r.cnt + 23'h000001;
    end
    n.irq = |(n.stat & n.ien);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      r <= '0;
      r.mode <= wwdt_pkg::WWDT_RUN;
      r.srcSel <= wwdt_pkg::WWDT_SRC_LOWRC;
      r.stat <= `WWDT_STAT_RST;
      r.ien <= `WWDT_IEN_RST;
      r.cnt <= `WWDT_CNT_RST;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign resetReq = r.rstReq;
  assign wakeReq = r.wake;
  assign clkSrcEnable = r.srcEn;
  assign irq = r.irq;
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_SLEEP_SRC: assert property (@(posedge clk_sys)
    disable iff (!nrst) r.mode == wwdt_pkg::WWDT_SLEEP |=>
    r.srcSel == wwdt_pkg::WWDT_SRC_LOWRC)
    else $error("sleep source not low-power rc");

  AST_SRC_EN: assert property (@(posedge clk_sys)
    disable iff (!nrst) enabled |=> clkSrcEnable)
    else $error("clock source not enabled");

  AST_BASE_PERIOD: assert property (@(posedge clk_sys)
    disable iff (!nrst) enabled && tick && !prescaleWidthSelect &&
    postscaleRatioSelect == 4'h0 && r.cnt == 23'h00001F |-> timeout)
    else $error("short base period wrong");

  AST_LONG_PERIOD: assert property (@(posedge clk_sys)
    disable iff (!nrst) enabled && tick && prescaleWidthSelect &&
    postscaleRatioSelect == 4'h1 && r.cnt == 23'h0000FF |-> timeout)
    else $error("postscale ratio wrong");

  AST_SWITCH_CLR: assert property (@(posedge clk_sys)
    disable iff (!nrst) clkSwitchDone |=> r.cnt == 23'h000000)
    else $error("count not cleared on clock switch");

  AST_PSAVE_CLR: assert property (@(posedge clk_sys)
    disable iff (!nrst) inRun && powerSaveCmd |=> r.cnt == 23'h000000 &&
    r.mode != wwdt_pkg::WWDT_RUN)
    else $error("power-save entry mishandled");

  AST_WAKE: assert property (@(posedge clk_sys)
    disable iff (!nrst) timeout && !inRun |=> wakeReq && !resetReq &&
    r.mode == wwdt_pkg::WWDT_RUN ##1 !wakeReq)
    else $error("wake not issued");

  AST_SLEEP_KEEP: assert property (@(posedge clk_sys)
    disable iff (!nrst) r.sleepFlag && !rctlWr |=> r.sleepFlag)
    else $error("sleep flag lost");

  AST_TMO_FLAG: assert property (@(posedge clk_sys)
    disable iff (!nrst) $rose(resetReq) |-> r.tmoFlag)
    else $error("reset without time-out flag");

  AST_LATE_CLR: assert property (@(posedge clk_sys)
    disable iff (!nrst) inRun && enabled && watchdogClearCmd && !early &&
    !timeout |=> !resetReq && r.cnt == 23'h000000)
    else $error("allowed clear mishandled");

  AST_EARLY_RST: assert property (@(posedge clk_sys)
    disable iff (!nrst) early |=> resetReq && r.stat[`WWDT_EV_EARLY])
    else $error("early clear did not reset");

  AST_OFF: assert property (@(posedge clk_sys)
    disable iff (!nrst) configEnableField == 2'h0 |=>
    r.cnt == 23'h000000 && !resetReq)
    else $error("disabled watchdog counted");

  AST_SOFT_RST: assert property (@(posedge clk_sys)
    !nrst |=> !r.softEn)
    else $error("soft enable survived reset");

  AST_RUN_TMO: assert property (@(posedge clk_sys)
    disable iff (!nrst) timeout && inRun |=> resetReq && !wakeReq)
    else $error("run time-out did not reset");

  COV_RUN_TMO: cover property (@(posedge clk_sys) disable iff (!nrst)
    timeout && inRun);
  COV_WAKE: cover property (@(posedge clk_sys) disable iff (!nrst)
    timeout && !inRun);
  COV_EARLY: cover property (@(posedge clk_sys) disable iff (!nrst)
    early);

endmodule // wwdt_top

/* windowed_watchdog_timer_test.sv */
`timescale 1ns/1ns
`include "wwdt_cfg.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module windowed_watchdog_timer_test;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] pins = 3'h0;
  logic [1:0] clkSel = 2'h0;
  logic [7:0] cfg = 8'h00;
  logic psw = 1'b0;
  logic clr = 1'b0;
  logic psCmd = 1'b0;
  logic psSleep = 1'b0;
  logic psExit = 1'b0;
  logic swDone = 1'b0;
  logic resetReq, wakeReq, clkSrcEnable, irq;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, v;
  int errors = 0;
  int comparisons = 0;
  int rstN = 0;
  int wakeN = 0;
  int rstExp = 0;
  int k;

  always #25 clk_sys = ~clk_sys;

  wwdt_top DUT (.clk_sys(clk_sys), .nrst(nrst), .lowPowerRcOsc(pins[0]),
    .secondaryOsc(pins[1]), .systemTimerClk(pins[2]), .clkSrcSelect(clkSel),
    .watchdogConfigWord(cfg), .prescaleWidthSelect(psw),
    .watchdogClearCmd(clr), .powerSaveCmd(psCmd), .powerSaveIsSleep(psSleep),
    .powerSaveExit(psExit), .clkSwitchDone(swDone), .resetReq(resetReq),
    .wakeReq(wakeReq), .clkSrcEnable(clkSrcEnable), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  ////////////////////////////////////////////////////////////////////////
  // Pulse counters
  always @(posedge clk_sys) begin
    if (resetReq === 1'b1) rstN++;
    if (wakeReq === 1'b1) wakeN++;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus and stimulus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 200) errors++;
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 200) errors++;
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input int e, input string nm);
    rd(a);
    `CHK(nm, e, v)
  endtask

  task automatic tick(input int s, input int c);
    repeat (c) begin
      pins[s] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      pins[s] <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic pulse(input int w);
    @(posedge clk_sys);
    case (w)
      0: clr <= 1'b1;
      1: psCmd <= 1'b1;
      2: psExit <= 1'b1;
      default: swDone <= 1'b1;
    endcase
    @(posedge clk_sys);
    {clr, psCmd, psExit, swDone} <= 4'h0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    void'($urandom(32'h917A));
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rchk(`WWDT_ADDR_RCTL, 0, "control");
    rchk(`WWDT_ADDR_STAT, 0, "status");
    rchk(`WWDT_ADDR_IEN, 0, "enable");
    `CHK("srcEnable", 1'b0, clkSrcEnable)
    tick(0, 40);
    rchk(`WWDT_ADDR_CNT, 0, "count");
    `CHK("resets", rstExp, rstN)
    $display("test reset and disabled done");
    cfg <= 8'hE0;
    k = $urandom_range(30, 1);
    tick(0, k);
    `CHK("srcEnable", 1'b1, clkSrcEnable)
    rchk(`WWDT_ADDR_CNT, k, "count");
    pulse(3);
    rchk(`WWDT_ADDR_CNT, 0, "count");
    clkSel <= 2'h2;
    tick(2, 32);
    rstExp++;
    `CHK("resets", rstExp, rstN)
    rchk(`WWDT_ADDR_RCTL, 32'h10, "control");
    rchk(`WWDT_ADDR_STAT, 1, "status");
    wr(`WWDT_ADDR_RCTL, 0);
    `CHK("bresp", `WWDT_RESP_OKAY, rs)
    rchk(`WWDT_ADDR_RCTL, 0, "control");
    clkSel <= 2'h0;
    $display("test run time-out done");
    for (int i = 0; i < 2; i++) begin
      psw <= (i == 1);
      cfg <= 8'hE2 - 8'(i);
      pulse(3);
      k = 128 << i;
      tick(0, k - 1);
      `CHK("resets", rstExp, rstN)
      rchk(`WWDT_ADDR_CNT, k - 1, "count");
      tick(0, 1);
      rstExp++;
      `CHK("resets", rstExp, rstN)
    end
    $display("test scaler periods done");
    psw <= 1'b0;
    cfg <= 8'h60;
    pulse(3);
    k = $urandom_range(23, 1);
    tick(0, k);
    pulse(0);
    rstExp++;
    `CHK("resets", rstExp, rstN)
    rchk(`WWDT_ADDR_STAT, 3, "status");
    tick(0, 24);
    pulse(0);
    `CHK("resets", rstExp, rstN)
    rchk(`WWDT_ADDR_CNT, 0, "count");
    wr(`WWDT_ADDR_CLR, 7);
    wr(`WWDT_ADDR_RCTL, 0);
    $display("test window done");
    cfg <= 8'hE0;
    clkSel <= 2'h1;
    tick(1, 3);
    psSleep <= 1'b1;
    pulse(1);
    rchk(`WWDT_ADDR_CNT, 0, "count");
    tick(1, 10);
    rchk(`WWDT_ADDR_CNT, 0, "count");
    tick(0, 32);
    `CHK("wakes", 1, wakeN)
    `CHK("resets", rstExp, rstN)
    rchk(`WWDT_ADDR_RCTL, 32'h18, "control");
    wr(`WWDT_ADDR_RCTL, 0);
    psSleep <= 1'b0;
    pulse(1);
    tick(1, 5);
    rchk(`WWDT_ADDR_CNT, 5, "count");
    pulse(2);
    rchk(`WWDT_ADDR_CNT, 0, "count");
    clkSel <= 2'h0;
    $display("test sleep and idle done");
    cfg <= 8'hC0;
    repeat (2) @(posedge clk_sys);
    `CHK("srcEnable", 1'b0, clkSrcEnable)
    wr(`WWDT_ADDR_RCTL, 32'h20);
    repeat (2) @(posedge clk_sys);
    `CHK("srcEnable", 1'b1, clkSrcEnable)
    rchk(`WWDT_ADDR_RCTL, 32'h20, "control");
    rchk(`WWDT_ADDR_STAT, 4, "status");
    wr(`WWDT_ADDR_IEN, 4);
    repeat (2) @(posedge clk_sys);
    `CHK("irq", 1'b1, irq)
    wr(`WWDT_ADDR_CLR, 4);
    repeat (2) @(posedge clk_sys);
    `CHK("irq", 1'b0, irq)
    wr(8'h14, 1);
    `CHK("bresp", `WWDT_RESP_SLVERR, rs)
    rd(8'h14);
    `CHK("rresp", `WWDT_RESP_SLVERR, rs)
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK("srcEnable", 1'b0, clkSrcEnable)
    rchk(`WWDT_ADDR_RCTL, 0, "control");
    $display("test soft enable and bus done");
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    conclude();
  end
endmodule // windowed_watchdog_timer_test
